// >>> rtl/usc_core.sv
// serial core: avalon register slave, transmitter, receiver, sync hunt, modem pins
// Operation
// - software stores one or two sync characters in a dedicated register for sync mode.
// - in sync mode an empty transmitter with no new character sends the stored sync characters.
// - in sync receive, sync is declared when received characters equal the stored ones.
// - a written character moves from the transmit buffer into the shifter and leaves serially.
// - the transmitter adds start, parity and stop bits as the mode selects.
// - the receiver assembles characters and places each in the receive buffer for reading.
// - in sync mode the receiver hunts for sync characters and checks parity.
// - in async mode the receiver detects start and stop bits and checks parity.
// - no async start bit is taken before mode, receive enable and one high stop level.
// - four modem pins are handled, and rts, dsr and dtr may serve as general pins.
// - transmitter empty is set only when both shifter and buffer hold nothing unsent.
// - a new character over an unread one sets overrun and overwrites the old one.
// - the serial output changes on the falling transmit clock edge, at 1, 16 or 64 per bit.
// - the serial input is sampled on the rising receive clock edge, at 1, 16 or 64 per bit.
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module usc_core #(
   parameter int ADDR_W = 5
) (
   // clock and reset
   input  wire logic              mclk_in,
   input  wire logic              rst_in,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0] avs_address_in,
   input  wire logic              avs_read_in,
   input  wire logic              avs_write_in,
   input  wire logic [31:0]       avs_writedata_in,
   input  wire logic [3:0]        avs_byteenable_in,
   output logic      [31:0]       avs_readdata_out,
   output logic                   avs_waitrequest_out,
   output logic                   irq_out,
   // serial line and its clocks
   input  wire logic              transmit_shift_clock_in,
   input  wire logic              receive_shift_clock_in,
   input  wire logic              serial_in_line_in,
   output logic                   serial_out_line_out,
   output logic                   transmitter_empty_out,
   output logic                   receive_char_available_out,
   // modem pins, active low on the wire; order rts, dsr, dtr
   input  wire logic              cts_n_in,
   input  wire logic [2:0]        modem_n_in,
   output logic      [2:0]        modem_n_out,
   output logic      [2:0]        modem_n_oe_out
);

   if (ADDR_W < 5)
   begin : g_bad_addr
      $error("usc_core needs ADDR_W of at least 5");
   end

   usc_pkg::usc_st_t st;
   usc_pkg::usc_st_t s;

   function automatic logic [2:0] reg_idx(input logic [ADDR_W-1:0] a);
      logic [4:0] lo;
      lo = a[4:0];
      if (a[ADDR_W-1:0] >> 5 != '0)
         reg_idx = 3'h7;
      else
         reg_idx = 3'(lo >> 2);
   endfunction : reg_idx

   function automatic logic [7:0] cmask(input logic [3:0] n);
      cmask = 8'(8'hFF >> (4'h8 - n));
   endfunction : cmask

   function automatic logic hunt_ok(input logic [15:0] h, input logic [3:0] n, input logic two,
                                    input logic [7:0] c1, input logic [7:0] c2);
      logic [7:0] last;
      logic [7:0] prev;
      logic [7:0] m;
      m    = cmask(n);
      last = 8'(h >> (5'h10 - {1'b0, n}));
      prev = 8'(h >> (5'h10 - {n, 1'b0}));
      if (two)
         hunt_ok = ((last & m) == (c2 & m)) && ((prev & m) == (c1 & m));
      else
         hunt_ok = (last & m) == (c1 & m);
   endfunction : hunt_ok

   logic [3:0]        n;
   localparam int     NSYW = usc_pkg::NSY;
   logic [5:0]        fm1;
   logic [NSYW-1:0]   chg;
   logic              tx_fall;
   logic              rx_rise;
   logic              line;
   logic              cts_ok;
   logic              bit_en;
   logic              fin;
   logic              done;
   logic              load;
   logic              cend;
   logic              dlv;
   logic              rd_data;
   logic              wr_acc;
   logic [2:0]        idx;
   logic [7:0]        ch;
   logic [31:0]       bem;
   logic [31:0]       wv;
   logic [31:0]       rv;
   logic [NSYW-1:0]   pins;
   logic [usc_pkg::NEV-1:0] ev;
   usc_pkg::usc_ctrl_t c;

   assign pins = {modem_n_in, cts_n_in, serial_in_line_in, receive_shift_clock_in, transmit_shift_clock_in};

   always_comb
   begin
      s       = st;
      c       = st.ctrl;
      ev      = '0;
      fin     = 1'b0;
      done    = 1'b0;
      load    = 1'b0;
      cend    = 1'b0;
      dlv     = 1'b0;
      ch      = 8'h00;
      rv      = 32'h0000_0000;
      idx     = reg_idx(avs_address_in);
      bem     = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                 {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
      wv      = avs_writedata_in & bem;
      n       = 4'(usc_pkg::CHAR_BASE + {2'b00, c.char_len});
      // sync mode shifts once per clock edge whatever the clock select says
      case (c.sync_mode ? 2'b00 : c.clk_sel)
         2'b00:   fm1 = usc_pkg::FM1_X1;
         2'b01:   fm1 = usc_pkg::FM1_X16;
         default: fm1 = usc_pkg::FM1_X64;
      endcase

      // three-stage pin capture; an edge counts once stages two and three agree
      s.s0    = pins;
      s.s1    = st.s0;
      s.s2    = st.s1;
      chg     = ~(st.s1 ^ st.s2) & (st.s2 ^ st.flt);
      s.flt   = st.flt ^ chg;
      tx_fall = chg[usc_pkg::SY_TXC] & ~st.s2[usc_pkg::SY_TXC];
      rx_rise = chg[usc_pkg::SY_RXC] & st.s2[usc_pkg::SY_RXC];
      line    = st.flt[usc_pkg::SY_RXD];
      cts_ok  = ~st.flt[usc_pkg::SY_CTS];

      // bus: first cycle of a request latches read data, second cycle completes it
      s.ack   = (avs_read_in | avs_write_in) & ~st.ack;
      wr_acc  = avs_write_in & st.ack;
      rd_data = avs_read_in & st.ack & (idx == 3'(usc_pkg::REG_DATA >> 2));
      if (avs_read_in & ~st.ack)
      begin
         case (idx)
            3'(usc_pkg::REG_DATA >> 2):  rv[7:0] = st.rbuf;
            3'(usc_pkg::REG_CTRL >> 2):  rv = 32'(st.ctrl);
            3'(usc_pkg::REG_SYNC >> 2):  rv = {16'h0000, st.sync2, st.sync1};
            3'(usc_pkg::REG_STAT >> 2):
            begin
               rv[usc_pkg::ST_TXRDY] = ~st.tbuf_full;
               rv[usc_pkg::ST_RXAV]  = st.ravail;
               rv[usc_pkg::ST_TXE]   = st.txe;
               rv[usc_pkg::ST_SYNC]  = st.synced;
               rv[usc_pkg::ST_ARMED] = st.armed;
               rv[usc_pkg::ST_MDM_IN +: 4] = ~st.flt[usc_pkg::SY_CTS +: 4];
            end
            3'(usc_pkg::REG_ISTAT >> 2): rv = 32'(st.istat);
            3'(usc_pkg::REG_IMASK >> 2): rv = 32'(st.mask);
            3'(usc_pkg::REG_MODEM >> 2): rv = 32'(st.modem);
            default:                     rv = 32'h0000_0000;
         endcase
         s.rdata = rv;
      end
      if (rd_data)
         s.ravail = 1'b0;

      // transmitter: one bit per fm1+1 falling edges of the transmit clock
      bit_en = tx_fall & (st.tsub == fm1);
      if (tx_fall)
         s.tsub = (st.tsub == fm1) ? 6'h00 : 6'(st.tsub + 6'h01);
      if (bit_en)
      begin
         case (st.tstate)
            usc_pkg::TX_IDLE:  done = 1'b1;
            usc_pkg::TX_START:
            begin
               s.tout   = st.tsh[0];
               s.tpar   = st.tsh[0];
               s.tsh    = st.tsh >> 1;
               s.tbits  = 4'h1;
               s.tstate = usc_pkg::TX_DATA;
            end
            usc_pkg::TX_DATA:
               if (st.tbits == n)
               begin
                  if (c.par_en & ~st.tfill)
                  begin
                     s.tout   = st.tpar ^ ~c.par_even;
                     s.tstate = usc_pkg::TX_PAR;
                  end
                  else
                     fin = 1'b1;
               end
               else
               begin
                  s.tout  = st.tsh[0];
                  s.tpar  = st.tpar ^ st.tsh[0];
                  s.tsh   = st.tsh >> 1;
                  s.tbits = 4'(st.tbits + 4'h1);
               end
            usc_pkg::TX_PAR:   fin = 1'b1;
            usc_pkg::TX_STOP:
               if (c.two_stop & (st.tbits == 4'h0))
                  s.tbits = 4'h1;
               else
                  done = 1'b1;
            default:           s.tstate = usc_pkg::TX_IDLE;
         endcase
      end
      if (fin)
      begin
         if (c.sync_mode)
            done = 1'b1;
         else
         begin
            s.tout   = 1'b1;
            s.tstate = usc_pkg::TX_STOP;
            s.tbits  = 4'h0;
         end
      end
      if (done)
      begin
         s.tstate = usc_pkg::TX_IDLE;
         s.tfill  = 1'b0;
         s.tout   = 1'b1;
         if (st.tbuf_full & c.tx_en & cts_ok)
         begin
            ch          = st.tbuf;
            s.tbuf_full = 1'b0;
            s.tfill2    = 1'b0;
            load        = 1'b1;
         end
         else if (c.sync_mode & c.mode_set & c.tx_en)
         begin
            // fill characters go out raw, without a parity bit
            ch       = st.tfill2 ? st.sync2 : st.sync1;
            s.tfill2 = c.two_sync & ~st.tfill2;
            s.tfill  = 1'b1;
            load     = 1'b1;
         end
         if (load & c.sync_mode)
         begin
            s.tout   = ch[0];
            s.tpar   = ch[0];
            s.tsh    = ch >> 1;
            s.tbits  = 4'h1;
            s.tstate = usc_pkg::TX_DATA;
         end
         else if (load)
         begin
            s.tout   = 1'b0;
            s.tsh    = ch;
            s.tstate = usc_pkg::TX_START;
         end
      end

      // receiver
      if (~(c.rx_en & c.mode_set))
      begin
         s.rstate = usc_pkg::RX_IDLE;
         s.armed  = 1'b0;
         s.synced = 1'b0;
         s.ravail = 1'b0;
      end
      else if (rx_rise)
      begin
         if (c.sync_mode & ~st.synced)
         begin
            s.hist = {line, st.hist[15:1]};
            if (hunt_ok(s.hist, n, c.two_sync, st.sync1, st.sync2))
            begin
               s.synced     = 1'b1;
               ev[usc_pkg::EV_SYN] = 1'b1;
               s.rstate     = usc_pkg::RX_DATA;
               s.rbits      = 4'h0;
               s.rpar       = 1'b0;
               s.rsub       = 6'h00;
            end
         end
         else if (st.rstate == usc_pkg::RX_IDLE)
         begin
            if (~c.sync_mode)
            begin
               if (line)
                  s.armed = 1'b1;
               else if (st.armed)
               begin
                  s.rpar   = 1'b0;
                  s.rbits  = 4'h0;
                  // x1 has no oversampling, so the next edge is already data
                  s.rstate = (fm1 == 6'h00) ? usc_pkg::RX_DATA : usc_pkg::RX_START;
                  s.rsub   = fm1 >> 1;
               end
            end
         end
         else if (st.rsub != 6'h00)
            s.rsub = 6'(st.rsub - 6'h01);
         else
         begin
            s.rsub = fm1;
            case (st.rstate)
               usc_pkg::RX_START:
                  s.rstate = line ? usc_pkg::RX_IDLE : usc_pkg::RX_DATA;
               usc_pkg::RX_DATA:
               begin
                  s.rsh   = {line, st.rsh[7:1]};
                  s.rpar  = st.rpar ^ line;
                  s.rbits = 4'(st.rbits + 4'h1);
                  if (st.rbits == 4'(n - 4'h1))
                  begin
                     if (c.par_en)
                        s.rstate = usc_pkg::RX_PAR;
                     else
                        cend = 1'b1;
                  end
               end
               usc_pkg::RX_PAR:
               begin
                  ev[usc_pkg::EV_PAR] = st.rpar ^ line ^ ~c.par_even;
                  cend = 1'b1;
               end
               usc_pkg::RX_STOP:
               begin
                  ev[usc_pkg::EV_FRM] = ~line;
                  s.armed  = line;
                  s.rstate = usc_pkg::RX_IDLE;
                  dlv      = 1'b1;
               end
               default: s.rstate = usc_pkg::RX_IDLE;
            endcase
            if (cend & c.sync_mode)
            begin
               dlv      = 1'b1;
               s.rstate = usc_pkg::RX_DATA;
               s.rbits  = 4'h0;
               s.rpar   = 1'b0;
            end
            else if (cend)
               s.rstate = usc_pkg::RX_STOP;
         end
      end
      if (dlv)
      begin
         s.rbuf  = 8'(s.rsh >> (4'h8 - n));
         ev[usc_pkg::EV_RX]  = 1'b1;
         ev[usc_pkg::EV_OVR] = st.ravail & ~rd_data;
         s.ravail = 1'b1;
      end

      // register writes take effect on the completing edge
      if (wr_acc)
      begin
         case (idx)
            3'(usc_pkg::REG_DATA >> 2):
               if (avs_byteenable_in[0])
               begin
                  s.tbuf      = avs_writedata_in[7:0];
                  s.tbuf_full = 1'b1;
               end
            3'(usc_pkg::REG_CTRL >> 2):
               s.ctrl = usc_pkg::usc_ctrl_t'(12'((32'(st.ctrl) & ~bem) | wv));
            3'(usc_pkg::REG_SYNC >> 2):
               {s.sync2, s.sync1} = 16'(({16'h0000, st.sync2, st.sync1} & ~bem) | wv);
            3'(usc_pkg::REG_ISTAT >> 2):
               s.istat = st.istat & ~wv[usc_pkg::NEV-1:0];
            3'(usc_pkg::REG_IMASK >> 2):
               s.mask = 6'((32'(st.mask) & ~bem) | wv);
            3'(usc_pkg::REG_MODEM >> 2):
               s.modem = 6'((32'(st.modem) & ~bem) | wv);
            default: ;
         endcase
      end

      s.txe = ~s.tbuf_full & ((s.tstate == usc_pkg::TX_IDLE) | s.tfill);
      ev[usc_pkg::EV_TXE] = s.txe & ~st.txe;
      // a new event wins over a clear in the same cycle
      s.istat = s.istat | ev;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         st       <= '0;
         st.modem <= usc_pkg::MODEM_RST;
         st.flt   <= '1;
         st.tout  <= 1'b1;
      end
      else
         st <= s;
   end

   assign avs_readdata_out           = st.rdata;
   assign avs_waitrequest_out        = (avs_read_in | avs_write_in) & ~st.ack;
   assign irq_out                    = |(st.istat & st.mask);
   assign serial_out_line_out        = st.tout;
   assign transmitter_empty_out      = st.txe;
   assign receive_char_available_out = st.ravail;
   assign modem_n_out                = ~st.modem[2:0];
   assign modem_n_oe_out             = st.modem[usc_pkg::MD_OE +: 3];

   a_txe_both_empty: assert property (@(posedge mclk_in) disable iff (rst_in)
      transmitter_empty_out |-> !st.tbuf_full && (st.tstate == usc_pkg::TX_IDLE || st.tfill))
      else $error("transmitter empty while data is unsent");

   a_tx_on_fall: assert property (@(posedge mclk_in) disable iff (rst_in)
      $changed(serial_out_line_out) |-> $past(tx_fall))
      else $error("serial output changed without a transmit clock fall");

   a_rx_on_rise: assert property (@(posedge mclk_in) disable iff (rst_in)
      $changed(st.rsh) |-> $past(rx_rise))
      else $error("receive shifter moved without a receive clock rise");

   a_overrun_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
      (dlv && st.ravail && !rd_data) |=> st.istat[usc_pkg::EV_OVR] && st.ravail)
      else $error("overrun not flagged on unread character");

   a_start_armed: assert property (@(posedge mclk_in) disable iff (rst_in)
      (st.rstate == usc_pkg::RX_IDLE && !st.ctrl.sync_mode) ##1 (st.rstate != usc_pkg::RX_IDLE)
      |-> $past(st.armed) && $past(st.ctrl.rx_en) && $past(st.ctrl.mode_set))
      else $error("async start taken before the receiver was armed");

   a_sync_fill: assert property (@(posedge mclk_in) disable iff (rst_in)
      (bit_en && st.tstate == usc_pkg::TX_IDLE && st.ctrl.sync_mode && st.ctrl.mode_set
       && st.ctrl.tx_en && !st.tbuf_full && !st.tfill2)
      |=> st.tfill && serial_out_line_out == $past(st.sync1[0]))
      else $error("sync fill character not sent");

   a_hunt_sync: assert property (@(posedge mclk_in) disable iff (rst_in)
      $rose(st.synced) |-> $past(rx_rise) && st.istat[usc_pkg::EV_SYN])
      else $error("sync declared without a receive edge or event");

   a_mid_sample: assert property (@(posedge mclk_in) disable iff (rst_in)
      (rx_rise && st.rstate == usc_pkg::RX_IDLE && st.armed && !line && !st.ctrl.sync_mode
       && st.ctrl.rx_en && st.ctrl.mode_set && st.ctrl.clk_sel == 2'b01)
      |=> st.rsub == 6'h07)
      else $error("x16 start not aimed at mid bit");

   a_bus_answer: assert property (@(posedge mclk_in) disable iff (rst_in)
      (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("bus request held waiting more than one cycle");

   a_read_clears: assert property (@(posedge mclk_in) disable iff (rst_in)
      rd_data && !dlv |=> !receive_char_available_out)
      else $error("data read did not clear character available");

endmodule : usc_core
`default_nettype wire

// >>> rtl/usc_pkg.sv
// shared constants, register map and state types for the serial core
package usc_pkg;

   // register byte offsets, one aligned word each
   localparam logic [4:0] REG_DATA  = 5'h00;
   localparam logic [4:0] REG_CTRL  = 5'h04;
   localparam logic [4:0] REG_SYNC  = 5'h08;
   localparam logic [4:0] REG_STAT  = 5'h0C;
   localparam logic [4:0] REG_ISTAT = 5'h10;
   localparam logic [4:0] REG_IMASK = 5'h14;
   localparam logic [4:0] REG_MODEM = 5'h18;

   // status word bit positions
   localparam int ST_TXRDY  = 0;
   localparam int ST_RXAV   = 1;
   localparam int ST_TXE    = 2;
   localparam int ST_SYNC   = 3;
   localparam int ST_ARMED  = 4;
   localparam int ST_MDM_IN = 8;

   // event bits of the interrupt status and mask registers
   localparam int EV_RX  = 0;
   localparam int EV_TXE = 1;
   localparam int EV_OVR = 2;
   localparam int EV_PAR = 3;
   localparam int EV_FRM = 4;
   localparam int EV_SYN = 5;
   localparam int NEV    = 6;

   // indices into the pin synchroniser vector
   localparam int SY_TXC = 0;
   localparam int SY_RXC = 1;
   localparam int SY_RXD = 2;
   localparam int SY_CTS = 3;
   localparam int SY_GP  = 4;
   localparam int NSY    = 7;

   // modem register: [2:0] assert rts/dsr/dtr, [5:3] drive enables
   localparam int         MD_OE     = 3;
   localparam logic [5:0] MODEM_RST = 6'h28;
   localparam logic [3:0] CHAR_BASE = 4'h5;
   localparam logic [5:0] FM1_X1    = 6'h00;
   localparam logic [5:0] FM1_X16   = 6'h0F;
   localparam logic [5:0] FM1_X64   = 6'h3F;

   typedef struct packed {
      logic       mode_set;
      logic       two_stop;
      logic       two_sync;
      logic       par_even;
      logic       par_en;
      logic [1:0] char_len;
      logic [1:0] clk_sel;
      logic       sync_mode;
      logic       rx_en;
      logic       tx_en;
   } usc_ctrl_t;

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} usc_tx_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} usc_rx_t;

   typedef struct packed {
      logic              ack;
      logic [31:0]       rdata;
      usc_ctrl_t         ctrl;
      logic [7:0]        sync1;
      logic [7:0]        sync2;
      logic [NEV-1:0]    istat;
      logic [NEV-1:0]    mask;
      logic [5:0]        modem;
      logic [NSY-1:0]    s0;
      logic [NSY-1:0]    s1;
      logic [NSY-1:0]    s2;
      logic [NSY-1:0]    flt;
      logic [7:0]        tbuf;
      logic              tbuf_full;
      usc_tx_t           tstate;
      logic [7:0]        tsh;
      logic [3:0]        tbits;
      logic [5:0]        tsub;
      logic              tfill;
      logic              tfill2;
      logic              tout;
      logic              tpar;
      logic              txe;
      usc_rx_t           rstate;
      logic [5:0]        rsub;
      logic [3:0]        rbits;
      logic [7:0]        rsh;
      logic              rpar;
      logic [15:0]       hist;
      logic              synced;
      logic              armed;
      logic [7:0]        rbuf;
      logic              ravail;
   } usc_st_t;

endpackage : usc_pkg

// >>> tb/tb_usart_sync_async_serial_core.sv
// self-checking bench for the serial core
`timescale 1ns/1ps
`default_nettype none
module tb_usart_sync_async_serial_core;
   logic        mclk, rst, rd, wr, irq, txc, rxc, rxd, txd, txe, rxav, cts_n, wreq;
   logic [4:0]  addr;
   logic [31:0] wdata, rdata, q;
   logic [3:0]  be;
   logic [2:0]  mdm_out, mdm_oe;
   logic [10:0] fr;
   int          err_count, checks_done, cyc;
   // undriven modem pins float high through their pull-ups
   wire  logic [2:0] mdm_lvl = ~mdm_oe | mdm_out;

   usc_core usc_core_inst (.mclk_in(mclk), .rst_in(rst), .avs_address_in(addr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wreq), .irq_out(irq), .transmit_shift_clock_in(txc),
      .receive_shift_clock_in(rxc), .serial_in_line_in(rxd), .serial_out_line_out(txd),
      .transmitter_empty_out(txe), .receive_char_available_out(rxav), .cts_n_in(cts_n),
      .modem_n_in(mdm_lvl), .modem_n_out(mdm_out), .modem_n_oe_out(mdm_oe));
   usc_line_model usc_line_model_inst (.serial_out_line_in(txd), .transmit_shift_clock_out(txc),
      .receive_shift_clock_out(rxc), .serial_in_line_out(rxd));

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // waitrequest is sampled at the rising edge; the write lands and read data is taken at that edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      addr <= a;
      wr <= w;
      rd <= ~w;
      wdata <= d;
      do @(posedge mclk); while (wreq !== 1'b0 && ++n < 50);
      if (n >= 50)
         err_count++;
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   task automatic wait_rx();
      int n;
      n = 0;
      while (rxav !== 1'b1 && n < 400)
      begin
         @(posedge mclk);
         n++;
      end
      if (n >= 400)
         err_count++;
   endtask : wait_rx

   // async frame as sent on the wire, lsb first: start, data, parity, stop
   function automatic logic [10:0] frm(input logic [7:0] d, input logic p);
      return {1'b1, p, d, 1'b0};
   endfunction : frm

   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run

   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         err_count++;
         complete_run();
      end
   end

   initial
   begin
      rst = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      addr = '0;
      wdata = '0;
      be = 4'hF;
      cts_n = 1'b0;
      cyc = 0;
      err_count = 0;
      checks_done = 0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("line idle", 32'h1, 32'(txd));
      chk("irq idle", 32'h0, 32'(irq));
      bus(1'b0, usc_pkg::REG_MODEM, '0);
      chk("modem reset", 32'h28, q);
      bus(1'b0, 5'h1C, '0);
      chk("unmapped", 32'h0, q);
      // async x1, 8 bits, even parity, tx and rx on
      bus(1'b1, usc_pkg::REG_CTRL, 32'h9E3);
      chk("tx empty idle", 32'h1, 32'(txe));
      bus(1'b1, usc_pkg::REG_DATA, 32'hA5);
      repeat (2) @(posedge mclk);
      chk("tx empty busy", 32'h0, 32'(txe));
      usc_line_model_inst.get_frame(fr);
      chk("tx frame", 32'(frm(8'hA5, 1'b0)), 32'(fr));
      repeat (20) @(posedge mclk);
      chk("tx empty done", 32'h1, 32'(txe));
      usc_line_model_inst.send_bits({5'h1F, frm(8'h3C, 1'b0)}, 11, 1);
      wait_rx();
      bus(1'b0, usc_pkg::REG_DATA, '0);
      chk("rx char", 32'h3C, q);
      @(posedge mclk);
      chk("rx avail cleared", 32'h0, 32'(rxav));
      // second character lands over an unread first one
      usc_line_model_inst.send_bits({5'h1F, frm(8'h11, 1'b0)}, 11, 1);
      usc_line_model_inst.send_bits({5'h1F, frm(8'h07, 1'b1)}, 11, 1);
      repeat (40) @(posedge mclk);
      bus(1'b0, usc_pkg::REG_ISTAT, '0);
      chk("overrun flag", 32'h4, q & 32'h4);
      bus(1'b0, usc_pkg::REG_DATA, '0);
      chk("overwritten char", 32'h07, q);
      usc_line_model_inst.send_bits({5'h1F, frm(8'h01, 1'b0)}, 11, 1);
      wait_rx();
      bus(1'b0, usc_pkg::REG_ISTAT, '0);
      chk("parity error", 32'h8, q & 32'h8);
      bus(1'b0, usc_pkg::REG_DATA, '0);
      // async x16: start is checked at mid bit, then every sixteenth rise
      bus(1'b1, usc_pkg::REG_CTRL, 32'h9EB);
      usc_line_model_inst.send_bits({5'h1F, frm(8'h5A, 1'b0)}, 11, 16);
      wait_rx();
      bus(1'b0, usc_pkg::REG_DATA, '0);
      chk("rx char x16", 32'h5A, q);
      bus(1'b1, usc_pkg::REG_IMASK, 32'h4);
      @(posedge mclk);
      chk("irq unmasked", 32'h1, 32'(irq));
      bus(1'b1, usc_pkg::REG_ISTAT, 32'h3F);
      @(posedge mclk);
      chk("irq cleared", 32'h0, 32'(irq));
      bus(1'b1, usc_pkg::REG_MODEM, 32'h3F);
      @(posedge mclk);
      chk("modem drive", 32'h38, {26'h0, mdm_oe, mdm_out});
      repeat (6) @(posedge mclk);
      bus(1'b0, usc_pkg::REG_STAT, '0);
      chk("modem levels", 32'hF, (q >> 8) & 32'hF);
      // sync mode: hunt for one stored character after a run of ones
      bus(1'b1, usc_pkg::REG_SYNC, 32'h16);
      bus(1'b1, usc_pkg::REG_CTRL, 32'h867);
      usc_line_model_inst.send_bits(16'h16FF, 16, 1);
      repeat (20) @(posedge mclk);
      bus(1'b0, usc_pkg::REG_STAT, '0);
      chk("sync found", 32'h8, q & 32'h8);
      complete_run();
   end
endmodule : tb_usart_sync_async_serial_core
`default_nettype wire

// >>> tb/usc_line_model.sv
// far station on the line: shift clocks, frame sender, frame catcher
`timescale 1ns/1ps
`default_nettype none
module usc_line_model (
   // line from the core
   input  wire logic serial_out_line_in,
   // clocks and line into the core
   output logic      transmit_shift_clock_out,
   output logic      receive_shift_clock_out,
   output logic      serial_in_line_out
);
   // reference clocks run free, phases unrelated to each other and to mclk
   initial
   begin
      transmit_shift_clock_out = 1'b1;
      forever #100 transmit_shift_clock_out = ~transmit_shift_clock_out;
   end
   initial
   begin
      receive_shift_clock_out = 1'b1;
      #37;
      forever #100 receive_shift_clock_out = ~receive_shift_clock_out;
   end
   initial serial_in_line_out = 1'b1;
   // bits go lsb first on the falling edge so the rising edge sees them settled; line returns to mark
   // each bit stands m receive clocks, so m matches the core's clock select
   task automatic send_bits(input logic [15:0] v, input int n, input int m);
      for (int i = 0; i < n; i++)
      begin
         repeat (m) @(negedge receive_shift_clock_out);
         serial_in_line_out <= v[i];
      end
      repeat (m) @(negedge receive_shift_clock_out);
      serial_in_line_out <= 1'b1;
   endtask : send_bits
   // a bit is read at the fall that launches the next one, so it has settled
   task automatic get_frame(output logic [10:0] f);
      int n;
      n = 0;
      f = '1;
      do @(negedge transmit_shift_clock_out); while (serial_out_line_in !== 1'b0 && ++n < 100);
      f[0] = serial_out_line_in;
      for (int i = 1; i < 11; i++)
      begin
         @(negedge transmit_shift_clock_out);
         f[i] = serial_out_line_in;
      end
   endtask : get_frame
endmodule : usc_line_model
`default_nettype wire
